// ==== inc/tap_defines.vh ====
`ifndef TAP_DEFINES_VH
`define TAP_DEFINES_VH

// ----------------------------------------------------------------------------
// Controller states
// ----------------------------------------------------------------------------
`define ST_RESET       4'h0
`define ST_IDLE        4'h1
`define ST_SEL_DR      4'h2
`define ST_CAP_DR      4'h3
`define ST_SHIFT_DR    4'h4
`define ST_EXIT1_DR    4'h5
`define ST_PAUSE_DR    4'h6
`define ST_EXIT2_DR    4'h7
`define ST_UPD_DR      4'h8
`define ST_SEL_IR      4'h9
`define ST_CAP_IR      4'ha
`define ST_SHIFT_IR    4'hb
`define ST_EXIT1_IR    4'hc
`define ST_PAUSE_IR    4'hd
`define ST_EXIT2_IR    4'he
`define ST_UPD_IR      4'hf

// ----------------------------------------------------------------------------
// Instruction register
// ----------------------------------------------------------------------------
`define IR_WIDTH       4
`define IR_CAPTURE     4'h1
`define INS_EXTEST     4'h0
`define INS_IDCODE     4'h1
`define INS_SAMPLE     4'h2
`define INS_PROG       4'h4
`define INS_DBG_SCAN   4'h8
`define INS_DBG_BREAK  4'h9
`define INS_BYPASS     4'hf

// ----------------------------------------------------------------------------
// Data registers
// ----------------------------------------------------------------------------
`define IDCODE_WIDTH   32
`define IDCODE_VALUE   32'h0000_0001
`define CHAIN_WIDTH    16
`define CHAIN_COUNT    5
`define CHAIN_IDX_W    3
`define CHAIN_BSCAN    3'h0
`define CHAIN_PROG     3'h1
`define CHAIN_SCAN     3'h2
`define CHAIN_BREAK    3'h3

`endif

// ==== hdl/chain_store.v ====
`timescale 1ns/1ns
`include "tap_defines.vh"

// Holds the parallel images of the long data chains; read data registered.
module chain_store (
    input  wire                       ref_clk,
    input  wire                       arst_n,
    input  wire                       wr_en,
    input  wire [`CHAIN_IDX_W-1:0]    wr_idx,
    input  wire [`CHAIN_WIDTH-1:0]    wr_data,
    input  wire [`CHAIN_IDX_W-1:0]    rd_idx,
    output reg  [`CHAIN_WIDTH-1:0]    rd_data
);

    reg [`CHAIN_WIDTH-1:0] mem_q [0:`CHAIN_COUNT-1];
    integer i;

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (i = 0; i < `CHAIN_COUNT; i = i + 1) begin
                mem_q[i] <= {`CHAIN_WIDTH{1'b0}};
            end
            rd_data <= {`CHAIN_WIDTH{1'b0}};
        end else begin
            if (wr_en) begin
                mem_q[wr_idx] <= wr_data;
            end
            rd_data <= mem_q[rd_idx];
        end
    end

endmodule // chain_store

// ==== hdl/jtag_tap_controller.v ====
`timescale 1ns/1ns
`include "tap_defines.vh"

module jtag_tap_controller (
    input  wire                    ref_clk,
    input  wire                    arst_n,
    input  wire                    test_port_enable_fuse,
    input  wire                    test_port_disable_bit,
    input  wire                    debug_enable_fuse,
    input  wire                    tck_pin,
    input  wire                    tms_pin,
    input  wire                    tdi_pin,
    input  wire [`CHAIN_WIDTH-1:0] bscan_capture,
    input  wire [`CHAIN_WIDTH-1:0] prog_capture,
    input  wire [`CHAIN_WIDTH-1:0] scan_capture,
    input  wire [`CHAIN_WIDTH-1:0] break_capture,
    output reg                     tdo_out,
    output reg                     tdo_oe,
    output wire                    port_active,
    output wire                    pin_pullup_en,
    output reg  [`IR_WIDTH-1:0]    instr_q,
    output wire [`CHAIN_WIDTH-1:0] chain_update,
    output reg                     chain_update_stb,
    output reg  [`CHAIN_IDX_W-1:0] chain_update_idx,
    output wire                    idle_active,
    output wire [3:0]              tap_state
);

    // ------------------------------------------------------------------------
    // Pin sampling
    // ------------------------------------------------------------------------
    // Three stages per pin; a change counts when stages two and three agree.
    reg [2:0] tck_s_q;
    reg [2:0] tms_s_q;
    reg [2:0] tdi_s_q;
    reg       tck_lvl_q;
    reg       tms_lvl_q;
    reg       tdi_lvl_q;

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tck_s_q   <= 3'h0;
            tms_s_q   <= 3'h7;
            tdi_s_q   <= 3'h7;
            tck_lvl_q <= 1'b0;
            tms_lvl_q <= 1'b1;
            tdi_lvl_q <= 1'b1;
        end else begin
            tck_s_q <= {tck_s_q[1:0], tck_pin};
            tms_s_q <= {tms_s_q[1:0], tms_pin};
            tdi_s_q <= {tdi_s_q[1:0], tdi_pin};
            if (tck_s_q[1] == tck_s_q[2]) begin
                tck_lvl_q <= tck_s_q[2];
            end
            if (tms_s_q[1] == tms_s_q[2]) begin
                tms_lvl_q <= tms_s_q[2];
            end
            if (tdi_s_q[1] == tdi_s_q[2]) begin
                tdi_lvl_q <= tdi_s_q[2];
            end
        end
    end

    wire tck_rise = (tck_s_q[1] == tck_s_q[2]) && tck_s_q[2] && !tck_lvl_q;
    wire tck_fall = (tck_s_q[1] == tck_s_q[2]) && !tck_s_q[2] && tck_lvl_q;
    // TMS/TDI settle well before TCK rises, so the filtered level is current.
    wire tms = tms_lvl_q;
    wire tdi = tdi_lvl_q;

    // ------------------------------------------------------------------------
    // Enable
    // ------------------------------------------------------------------------
    // No test-reset pin exists; a disabled port holds the controller in reset.
    assign port_active   = test_port_enable_fuse && !test_port_disable_bit;
    assign pin_pullup_en = port_active;
    wire   hold_reset    = !port_active;

    // ------------------------------------------------------------------------
    // State machine
    // ------------------------------------------------------------------------
    reg [3:0] state_q;
    reg [3:0] state_d;

    always @* begin
        case (state_q)
            `ST_RESET:    state_d = tms ? `ST_RESET : `ST_IDLE;
            `ST_IDLE:     state_d = tms ? `ST_SEL_DR : `ST_IDLE;
            `ST_SEL_DR:   state_d = tms ? `ST_SEL_IR : `ST_CAP_DR;
            `ST_CAP_DR:   state_d = tms ? `ST_EXIT1_DR : `ST_SHIFT_DR;
            `ST_SHIFT_DR: state_d = tms ? `ST_EXIT1_DR : `ST_SHIFT_DR;
            `ST_EXIT1_DR: state_d = tms ? `ST_UPD_DR : `ST_PAUSE_DR;
            `ST_PAUSE_DR: state_d = tms ? `ST_EXIT2_DR : `ST_PAUSE_DR;
            `ST_EXIT2_DR: state_d = tms ? `ST_UPD_DR : `ST_SHIFT_DR;
            `ST_UPD_DR:   state_d = tms ? `ST_SEL_DR : `ST_IDLE;
            `ST_SEL_IR:   state_d = tms ? `ST_RESET : `ST_CAP_IR;
            `ST_CAP_IR:   state_d = tms ? `ST_EXIT1_IR : `ST_SHIFT_IR;
            `ST_SHIFT_IR: state_d = tms ? `ST_EXIT1_IR : `ST_SHIFT_IR;
            `ST_EXIT1_IR: state_d = tms ? `ST_UPD_IR : `ST_PAUSE_IR;
            `ST_PAUSE_IR: state_d = tms ? `ST_EXIT2_IR : `ST_PAUSE_IR;
            `ST_EXIT2_IR: state_d = tms ? `ST_UPD_IR : `ST_SHIFT_IR;
            `ST_UPD_IR:   state_d = tms ? `ST_SEL_DR : `ST_IDLE;
            default:      state_d = `ST_RESET;
        endcase
    end

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= `ST_RESET;
        end else if (hold_reset) begin
            state_q <= `ST_RESET;
        end else if (tck_rise) begin
            state_q <= state_d;
        end
    end

    assign tap_state   = state_q;
    assign idle_active = (state_q == `ST_IDLE);

    // ------------------------------------------------------------------------
    // Instruction register
    // ------------------------------------------------------------------------
    reg [`IR_WIDTH-1:0] ir_sh_q;

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ir_sh_q <= `IR_CAPTURE;
            instr_q <= `INS_IDCODE;
        end else if (hold_reset) begin
            ir_sh_q <= `IR_CAPTURE;
            instr_q <= `INS_IDCODE;
        end else if (tck_rise) begin
            // Latch as the state is entered, so that the new instruction
            // and its Update-IR or Test-Logic-Reset state appear together.
            if (state_d == `ST_RESET) begin
                instr_q <= `INS_IDCODE;
            end else if (state_d == `ST_UPD_IR) begin
                instr_q <= ir_sh_q;
            end
            case (state_q)
                `ST_CAP_IR:   ir_sh_q <= `IR_CAPTURE;
                `ST_SHIFT_IR: ir_sh_q <= {tdi, ir_sh_q[`IR_WIDTH-1:1]};
                default:      ir_sh_q <= ir_sh_q;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Data register selection
    // ------------------------------------------------------------------------
    // Debug chains fall back to bypass unless the debug fuse is programmed.
    function [`CHAIN_IDX_W:0] chain_sel;
        input [`IR_WIDTH-1:0] ins;
        input                 dbg;
        begin
            case (ins)
                `INS_EXTEST,
                `INS_SAMPLE:    chain_sel = {1'b1, `CHAIN_BSCAN};
                `INS_PROG:      chain_sel = {1'b1, `CHAIN_PROG};
                `INS_DBG_SCAN:  chain_sel = {dbg, `CHAIN_SCAN};
                `INS_DBG_BREAK: chain_sel = {dbg, `CHAIN_BREAK};
                default:        chain_sel = {1'b0, `CHAIN_BSCAN};
            endcase
        end
    endfunction

    wire [`CHAIN_IDX_W:0]   sel = chain_sel(instr_q, debug_enable_fuse);
    wire                    use_chain = sel[`CHAIN_IDX_W];
    wire [`CHAIN_IDX_W-1:0] chain_idx = sel[`CHAIN_IDX_W-1:0];
    wire                    use_id = (instr_q == `INS_IDCODE);

    reg [`CHAIN_WIDTH-1:0] cap_val;
    always @* begin
        case (chain_idx)
            `CHAIN_BSCAN: cap_val = bscan_capture;
            `CHAIN_PROG:  cap_val = prog_capture;
            `CHAIN_SCAN:  cap_val = scan_capture;
            `CHAIN_BREAK: cap_val = break_capture;
            default:      cap_val = {`CHAIN_WIDTH{1'b0}};
        endcase
    end

    // ------------------------------------------------------------------------
    // Data shift registers
    // ------------------------------------------------------------------------
    reg [`IDCODE_WIDTH-1:0] id_sh_q;
    reg [`CHAIN_WIDTH-1:0]  ch_sh_q;
    reg                     byp_q;

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            id_sh_q <= {`IDCODE_WIDTH{1'b0}};
            ch_sh_q <= {`CHAIN_WIDTH{1'b0}};
            byp_q   <= 1'b0;
        end else if (tck_rise && state_q == `ST_CAP_DR) begin
            id_sh_q <= `IDCODE_VALUE;
            ch_sh_q <= cap_val;
            byp_q   <= 1'b0;
        end else if (tck_rise && state_q == `ST_SHIFT_DR) begin
            if (use_id) begin
                id_sh_q <= {tdi, id_sh_q[`IDCODE_WIDTH-1:1]};
            end else if (use_chain) begin
                ch_sh_q <= {tdi, ch_sh_q[`CHAIN_WIDTH-1:1]};
            end else begin
                byp_q <= tdi;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Parallel update
    // ------------------------------------------------------------------------
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            chain_update_stb <= 1'b0;
            chain_update_idx <= `CHAIN_BSCAN;
        end else begin
            // Strobe on entry, so the write lands while Update-DR is current.
            chain_update_stb <= tck_rise && !hold_reset && use_chain
                                && state_d == `ST_UPD_DR;
            if (tck_rise && state_d == `ST_UPD_DR) begin
                chain_update_idx <= chain_idx;
            end
        end
    end

    chain_store u_store (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .wr_en   (chain_update_stb),
        .wr_idx  (chain_update_idx),
        .wr_data (ch_sh_q),
        .rd_idx  (chain_update_idx),
        .rd_data (chain_update)
    );

    // ------------------------------------------------------------------------
    // TDO
    // ------------------------------------------------------------------------
    // Changes on falling TCK, or when a port disable clears it, so the host samples a stable bit.
    wire shifting = (state_q == `ST_SHIFT_IR) || (state_q == `ST_SHIFT_DR);
    wire dr_bit   = use_id ? id_sh_q[0] : (use_chain ? ch_sh_q[0] : byp_q);

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tdo_out <= 1'b0;
            tdo_oe  <= 1'b0;
        end else if (hold_reset) begin
            tdo_out <= 1'b0;
            tdo_oe  <= 1'b0;
        end else if (tck_fall) begin
            tdo_oe  <= shifting;
            // Parked low outside shifts, so that a later port disable
            // cannot move it while TCK is high.
            if (!shifting) begin
                tdo_out <= 1'b0;
            end else if (state_q == `ST_SHIFT_IR) begin
                tdo_out <= ir_sh_q[0];
            end else begin
                tdo_out <= dr_bit;
            end
        end
    end

endmodule // jtag_tap_controller

// ==== testbench/jtag_tap_props.sv ====
`timescale 1ns/1ns
`include "tap_defines.vh"
module jtag_tap_props (
    input wire                 ref_clk,
    input wire                 arst_n,
    input wire                 tck_pin,
    input wire                 tdo_out,
    input wire                 tdo_oe,
    input wire                 port_active,
    input wire [`IR_WIDTH-1:0] instr_q,
    input wire                 chain_update_stb,
    input wire                 idle_active,
    input wire [3:0]           tap_state
);
    // ------------------------------------------------------------
    // Port timing checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    a_off_reset: assert property (
        !port_active |=> tap_state == `ST_RESET && !tdo_oe)
        else $error("disabled port left reset");
    // The driver turns off at the fall after leaving shift, so exit counts.
    a_oe_shifting: assert property (
        tdo_oe |-> tap_state inside {`ST_SHIFT_DR, `ST_EXIT1_DR,
            `ST_SHIFT_IR, `ST_EXIT1_IR})
        else $error("TDO driven outside a shift");
    a_idle_flag: assert property (
        idle_active == (tap_state == `ST_IDLE))
        else $error("idle flag wrong");
    a_stb_update: assert property (
        chain_update_stb |-> tap_state == `ST_UPD_DR)
        else $error("chain update outside update state");
    a_stb_pulse: assert property (
        chain_update_stb |=> !chain_update_stb)
        else $error("chain update strobe too long");
    a_instr_latch: assert property (
        !$stable(instr_q) |-> tap_state inside {`ST_UPD_IR, `ST_RESET})
        else $error("instruction changed outside update");
    a_tdo_fall: assert property (
        !$stable(tdo_out) |-> !$past(tck_pin, 2))
        else $error("TDO changed while TCK high");
    a_state_rise: assert property (
        !$stable(tap_state) && port_active |-> $past(tck_pin))
        else $error("state moved without TCK rise");
endmodule // jtag_tap_props

bind jtag_tap_controller jtag_tap_props u_props (.ref_clk, .arst_n,
    .tck_pin, .tdo_out, .tdo_oe, .port_active, .instr_q,
    .chain_update_stb, .idle_active, .tap_state);

// ==== testbench/jtag_host_model.sv ====
`timescale 1ns/1ns
module jtag_host_model (
    input  wire ref_clk,
    input  wire tdo_out,
    input  wire tdo_oe,
    output reg  tck_pin,
    output reg  tms_pin,
    output reg  tdi_pin
);
    // ------------------------------------------------------------
    // Serial access, TCK stands low between bits
    // ------------------------------------------------------------
    // A released TDO reads high through the board pull-up it needs.
    wire tdo_line = tdo_oe ? tdo_out : 1'b1;
    reg  tdo_v;
    initial begin
        tck_pin = 1'b0;
        tms_pin = 1'b1;
        tdi_pin = 1'b1;
    end
    // TDO is read late in the high phase, long after it settled.
    task clk_bit(input tms_v, input tdi_v);
        begin
            tms_pin = tms_v;
            tdi_pin = tdi_v;
            repeat (4) @(posedge ref_clk);
            #1 tck_pin = 1'b1;
            repeat (4) @(posedge ref_clk);
            #1 tdo_v = tdo_line;
            tck_pin = 1'b0;
        end
    endtask
    task nav(input [7:0] seq, input integer n);
        integer i;
        for (i = 0; i < n; i = i + 1) clk_bit(seq[i], 1'b1);
    endtask
    task shift(input integer n, input [31:0] din, output [31:0] dout);
        integer i;
        begin
            dout = 32'h0;
            for (i = 0; i < n; i = i + 1) begin
                clk_bit(i == n - 1, din[i]);
                dout[i] = tdo_v;
            end
        end
    endtask
    task ir(input [3:0] ins, output [31:0] cap);
        begin
            nav(8'h03, 4);
            shift(4, {28'h0, ins}, cap);
            nav(8'h01, 2);
        end
    endtask
    task dr(input integer n, input [31:0] din, output [31:0] dout);
        begin
            nav(8'h01, 3);
            shift(n, din, dout);
            nav(8'h01, 2);
        end
    endtask
endmodule // jtag_host_model

// ==== testbench/jtag_tap_controller_tb.sv ====
`timescale 1ns/1ns
`include "tap_defines.vh"
module jtag_tap_controller_tb;
    // Chain instructions, the one for chain index k at bits 4k; the last
    // is a debug code that is sent with the debug fuse off.
    localparam [19:0] INS_TAB = 20'h89840;
    reg                     ref_clk               = 1'b0;
    reg                     arst_n                = 1'b0;
    reg                     test_port_enable_fuse = 1'b1;
    reg                     test_port_disable_bit = 1'b0;
    reg                     debug_enable_fuse     = 1'b1;
    reg  [`CHAIN_WIDTH-1:0] cap [0:3];
    reg  [31:0]             d;
    integer                 err_total = 0;
    integer                 cmp_count = 0;
    integer                 stb_cnt   = 0;
    integer                 k;
    wire                    tck_pin, tms_pin, tdi_pin, tdo_out, tdo_oe;
    wire                    port_active, pin_pullup_en, idle_active;
    wire                    chain_update_stb;
    wire [`IR_WIDTH-1:0]    instr_q;
    wire [3:0]              tap_state;
    wire [`CHAIN_WIDTH-1:0] chain_update;
    wire [`CHAIN_IDX_W-1:0] chain_update_idx;

    jtag_tap_controller uut (
        .ref_clk, .arst_n, .test_port_enable_fuse, .test_port_disable_bit,
        .debug_enable_fuse, .tck_pin, .tms_pin, .tdi_pin,
        .bscan_capture(cap[0]), .prog_capture(cap[1]),
        .scan_capture(cap[2]), .break_capture(cap[3]),
        .tdo_out, .tdo_oe, .port_active, .pin_pullup_en, .instr_q,
        .chain_update, .chain_update_stb, .chain_update_idx,
        .idle_active, .tap_state);
    jtag_host_model host (
        .ref_clk, .tdo_out, .tdo_oe, .tck_pin, .tms_pin, .tdi_pin);

    // ------------------------------------------------------------
    // Checking and scenarios
    // ------------------------------------------------------------
    always #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
        if (chain_update_stb === 1'b1) stb_cnt = stb_cnt + 1;

    task check(input string nm, input [31:0] e, input [31:0] g);
        begin
            cmp_count = cmp_count + 1;
            if (g !== e) begin
                err_total = err_total + 1;
                $display("FAIL %s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task results;
        begin
            if (err_total == 0 && cmp_count > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    task t_start;
        begin
            check("state", `ST_RESET, tap_state);
            check("instr", `INS_IDCODE, instr_q);
            check("pullup", 1, pin_pullup_en);
            host.nav(8'h00, 1);
            check("idle", 1, idle_active);
            host.dr(32, 32'h5555_aaaa, d);
            check("idcode", `IDCODE_VALUE, d);
        end
    endtask
    task t_ir;
        begin
            host.nav(8'h03, 4);
            host.shift(4, `INS_BYPASS, d);
            check("ir_cap", `IR_CAPTURE, d);
            host.nav(8'h02, 2);
            check("exit2", `ST_EXIT2_IR, tap_state);
            check("oe_off", 0, tdo_oe);
            check("ins_hold", `INS_IDCODE, instr_q);
            host.nav(8'h01, 2);
            check("ins_new", `INS_BYPASS, instr_q);
        end
    endtask
    task t_bypass;
        for (k = 0; k < 2; k = k + 1) begin
            host.ir(k ? `INS_BYPASS : 4'h3, d);
            host.dr(8, 32'ha5, d);
            check("bypass", 32'h4a, d);
        end
    endtask
    task t_chains;
        integer n0;
        for (k = 0; k < 5; k = k + 1) begin
            n0 = stb_cnt;
            debug_enable_fuse = (k < 4);
            host.ir(INS_TAB[4*k +: 4], d);
            host.dr(16, {16'h0, ~cap[k%4]}, d);
            if (k < 4) begin
                check("chain", cap[k], d);
                check("upd", {16'h0, ~cap[k]}, chain_update);
                check("idx", k, chain_update_idx);
                check("stb", n0 + 1, stb_cnt);
            end else begin
                check("nodbg", {~cap[0][14:0], 1'b0}, d);
                check("nostb", n0, stb_cnt);
            end
        end
    endtask
    task t_off;
        begin
            for (k = 0; k < 2; k = k + 1) begin
                test_port_enable_fuse = k[0];
                test_port_disable_bit = k[0];
                host.nav(8'h03, 3);
                check("off_st", `ST_RESET, tap_state);
                check("off_act", 0, port_active);
                check("off_pu", 0, pin_pullup_en);
            end
            test_port_enable_fuse = 1'b1;
            test_port_disable_bit = 1'b0;
            host.nav(8'h00, 1);
        end
    endtask
    task t_tlr;
        begin
            host.ir(`INS_BYPASS, d);
            host.nav(8'h01, 3);
            host.nav(8'h1f, 5);
            check("tlr", `ST_RESET, tap_state);
            check("tlr_ins", `INS_IDCODE, instr_q);
            host.nav(8'h00, 1);
            host.ir(`INS_BYPASS, d);
            arst_n = 1'b0;
            repeat (2) @(posedge ref_clk);
            check("rst_st", `ST_RESET, tap_state);
            check("rst_ins", `INS_IDCODE, instr_q);
            #1 arst_n = 1'b1;
        end
    endtask

    initial begin
        for (k = 0; k < 4; k = k + 1) cap[k] = 16'h1111 * (k + 1) ^ 16'h0f0f;
        repeat (10) @(posedge ref_clk);
        #1 arst_n = 1'b1;
        t_start;
        t_ir;
        t_bypass;
        t_chains;
        t_off;
        t_tlr;
        results;
    end
    initial begin
        repeat (90000) @(posedge ref_clk);
        err_total = err_total + 1;
        results;
    end
endmodule // jtag_tap_controller_tb
